// ===== bench/acs_analog_src.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// analog source on the selected channel, plus the rc oscillator
module acs_analog_src
	import acs_pkg::*;
(
	input wire logic aclk,
	input wire logic converter_enable,
	input wire logic [RESULT_BITS-1:0] sar_trial,
	input wire logic [RESULT_BITS-1:0] level,
	output logic comparator_high,
	output logic rc_tick
);
	logic [2:0] rc_cnt = 3'h0;
	logic noise = 1'h0;

	// rc oscillator runs free, one tick every five clocks
	always_ff @(posedge aclk) begin
		rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
		noise <= ~noise;
	end
	assign rc_tick = (rc_cnt == 3'h4);

	// source held steady
	// powered down the comparator only gives noise, so no bit matches by luck
	assign comparator_high = converter_enable ? (level >= sar_trial) : noise;
endmodule : acs_analog_src

`default_nettype wire

// ===== bench/tb_adc_conversion_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module tb_adc_conversion_sequencer
	import acs_pkg::*;
;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [AXI_ADDR_W-1:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
	logic [AXI_DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sleep_active = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic rc_tick, comparator_high, converter_enable, sample_hold, reference_select;
	logic wake_pulse, vector_request;
	logic [RESULT_BITS-1:0] sar_trial, level = 10'h000, last = 10'h000;
	logic [2:0] channel_select;
	logic [7:0] analog_pins;
	logic last_j = 1'h0;
	logic [31:0] lfsr = 32'h2A3D;
	int miscompares = 0, tests_run = 0, cycles = 0, wakes = 0, vecs = 0;

	acs_sequencer u_acs_sequencer (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.sleep_active, .rc_tick, .comparator_high, .converter_enable, .sample_hold,
		.sar_trial, .channel_select, .reference_select, .analog_pins, .wake_pulse,
		.vector_request);
	acs_analog_src u_acs_analog_src (.aclk, .converter_enable, .sar_trial, .level,
		.comparator_high, .rc_tick);

	// ==========================================================
	// clock, wake counters and the hang guard
	initial begin
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		wakes <= wakes + int'(wake_pulse);
		vecs <= vecs + int'(vector_request);
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	// ==========================================================
	// compare, report and stimulus helpers
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: resp %h expected %h", $time, got, exp);
		end
	endtask : chk_resp
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_step
	// bit period in clocks; the rc oscillator of the source model ticks every five
	function automatic int div_of(input logic [2:0] c);
		return (c[1:0] == 2'h3) ? 5 : (c[2] ? 4 : 2) << (2 * c[1:0]);
	endfunction : div_of
	function automatic logic [7:0] exp_res(input logic [9:0] r, input logic j, input logic hi);
		if (hi)
			return j ? {6'h00, r[9:8]} : r[9:2];
		return j ? r[7:0] : {r[1:0], 6'h00};
	endfunction : exp_res

	// write and read hold each channel until its own handshake
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axi_rd
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [1:0] r;
		axi_wr(idx, d, r);
		chk_resp(r, RESP_OKAY);
	endtask : wr
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(idx, d, r);
		chk_resp(r, RESP_OKAY);
		chk_val(d, {24'h000000, exp});
	endtask : rd_chk

	// ==========================================================
	// configure, acquire, then set go; level is the channel voltage
	task automatic start(input logic [2:0] code, input logic j, input logic [2:0] ch);
		lfsr = lfsr_step(lfsr);
		level <= lfsr[9:0];
		wr(IDX_CONVERTER_CONTROL_B, {1'h0, code, 4'h0});
		wr(IDX_CONVERTER_CONTROL_A, {j, 2'h0, ch, 2'h1});
		repeat (2 * div_of(code) + 20) @(posedge aclk);
		wr(IDX_CONVERTER_CONTROL_A, {j, 2'h0, ch, 2'h3});
	endtask : start
	task automatic check_result(input logic j);
		last = level;
		last_j = j;
		rd_chk(IDX_RESULT_HIGH, exp_res(last, j, 1'h1));
		rd_chk(IDX_RESULT_LOW, exp_res(last, j, 1'h0));
		rd_chk(IDX_PERIPHERAL_FLAGS, 8'h40);
		wr(IDX_PERIPHERAL_FLAGS, 8'h00);
	endtask : check_result
	task automatic done_test(input string s);
		$display("test %s finished at %0t", s, $time);
	endtask : done_test

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [2:0] ch;
		logic j;
		int t0, per, w0, v0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		rd_chk(IDX_ANALOG_PIN_SELECT, RST_ANALOG_PIN_SELECT);
		rd_chk(IDX_CONVERTER_CONTROL_A, RST_CONVERTER_CONTROL);
		rd_chk(IDX_CONVERTER_CONTROL_B, RST_CONVERTER_CONTROL);
		rd_chk(IDX_PERIPHERAL_FLAGS, RST_PERIPHERAL_FLAGS);
		rd_chk(IDX_PERIPHERAL_ENABLES, RST_PERIPHERAL_ENABLES);
		rd_chk(IDX_INTERRUPT_CONTROL, RST_INTERRUPT_CONTROL);
		axi_rd(8'h00, d, r);
		chk_resp(r, RESP_SLVERR);
		axi_wr(8'h00, 8'hFF, r);
		chk_resp(r, RESP_SLVERR);
		wr(IDX_CONVERTER_CONTROL_A, 8'h02);
		rd_chk(IDX_CONVERTER_CONTROL_A, 8'h00);
		lfsr = lfsr_step(lfsr);
		wr(IDX_ANALOG_PIN_SELECT, lfsr[7:0]);
		rd_chk(IDX_ANALOG_PIN_SELECT, lfsr[7:0]);
		chk_val(analog_pins, lfsr[7:0]);
		done_test("reset and access");
		// every clock select code, polled completion with duration window
		for (int i = 0; i < 8; i++) begin
			j = lfsr[12];
			ch = lfsr[15:13];
			per = div_of(3'(i));
			start(3'(i), j, ch);
			t0 = cycles;
			do axi_rd(IDX_CONVERTER_CONTROL_A, d, r); while (d[1] === 1'h1);
			t0 = cycles - t0 - 11 * per - ((i % 4 == 3) ? 4 : 0);
			chk_val(32'(t0 >= -per && t0 <= per + 12), 32'h1);
			if (i == 6) begin
				wr(IDX_CONVERTER_CONTROL_A, {j, 2'h0, ch, 2'h3});
				rd_chk(IDX_CONVERTER_CONTROL_A, {j, 2'h0, ch, 2'h1});
			end
			check_result(j);
			chk_val(channel_select, ch);
			chk_val(sample_hold, 1'h1);
		end
		done_test("clock codes");
		// software abort keeps the previous result
		start(3'h2, 1'h0, 3'h1);
		repeat (100) @(posedge aclk);
		wr(IDX_CONVERTER_CONTROL_A, 8'h05);
		rd_chk(IDX_PERIPHERAL_FLAGS, 8'h00);
		rd_chk(IDX_RESULT_LOW, exp_res(last, last_j, 1'h0));
		// sleep with a divided clock aborts and powers down
		start(3'h6, 1'h0, 3'h2);
		repeat (100) @(posedge aclk);
		sleep_active <= 1'h1;
		repeat (5) @(posedge aclk);
		chk_val(converter_enable, 1'h0);
		rd_chk(IDX_CONVERTER_CONTROL_A, 8'h09);
		sleep_active <= 1'h0;
		rd_chk(IDX_RESULT_HIGH, exp_res(last, last_j, 1'h1));
		done_test("aborts");
		// rc conversion in sleep wakes, vectors only with global enable
		wr(IDX_PERIPHERAL_ENABLES, 8'h40);
		for (int g = 1; g >= 0; g--) begin
			wr(IDX_INTERRUPT_CONTROL, g ? 8'hC0 : 8'h40);
			start(3'h3, 1'h1, 3'h4);
			sleep_active <= 1'h1;
			w0 = wakes;
			v0 = vecs;
			while (wakes == w0) @(posedge aclk);
			sleep_active <= 1'h0;
			chk_val(vecs - v0, g);
			check_result(1'h1);
		end
		// rc conversion in sleep without its enable powers down, power bit kept
		wr(IDX_PERIPHERAL_ENABLES, 8'h00);
		start(3'h7, 1'h0, 3'h5);
		sleep_active <= 1'h1;
		w0 = wakes;
		repeat (100) @(posedge aclk);
		chk_val(converter_enable, 1'h0);
		chk_val(wakes - w0, 0);
		rd_chk(IDX_CONVERTER_CONTROL_A, 8'h15);
		sleep_active <= 1'h0;
		check_result(1'h0);
		done_test("sleep");
		// reset mid-conversion clears control but keeps the result pair
		start(3'h6, 1'h0, 3'h6);
		repeat (100) @(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		chk_val(converter_enable, 1'h0);
		rd_chk(IDX_CONVERTER_CONTROL_A, 8'h00);
		rd_chk(IDX_RESULT_HIGH, exp_res(last, 1'h0, 1'h1));
		done_test("reset");
		final_report();
	end
endmodule : tb_adc_conversion_sequencer

`default_nettype wire

// ===== src/acs_pkg.sv
package acs_pkg;

	// ==========================================================
	// bus geometry
	localparam int AXI_ADDR_W = 10;
	localparam int AXI_DATA_W = 32;

	// ==========================================================
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
	localparam logic [7:0] IDX_PERIPHERAL_FLAGS = 8'h0C;
	localparam logic [7:0] IDX_RESULT_HIGH = 8'h1E;
	localparam logic [7:0] IDX_CONVERTER_CONTROL_A = 8'h1F;
	localparam logic [7:0] IDX_PERIPHERAL_ENABLES = 8'h8C;
	localparam logic [7:0] IDX_ANALOG_PIN_SELECT = 8'h91;
	localparam logic [7:0] IDX_RESULT_LOW = 8'h9E;
	localparam logic [7:0] IDX_CONVERTER_CONTROL_B = 8'h9F;

	// ==========================================================
	// field positions and reset values
	localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
	localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
	localparam int BIT_CONVERSION_DONE_FLAG = 6;
	localparam int BIT_CONVERSION_IRQ_ENABLE = 6;
	localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_FLAGS = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_ENABLES = 8'h00;
	localparam logic [7:0] RST_ANALOG_PIN_SELECT = 8'hFF;
	localparam logic [7:0] RST_CONVERTER_CONTROL = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// timing: counts in conversion bit periods or system clocks
	localparam int RESULT_BITS = 10;
	localparam logic [3:0] CONV_TADS = 4'hB;
	localparam logic [3:0] GAP_TADS = 4'h2;
	localparam logic [3:0] START_DELAY_CLKS = 4'h4;
	localparam logic [2:0] CLK_SEL_RC_LOW = 3'h3;
	localparam logic [5:0] DIV_LAST_2 = 6'h01;
	localparam logic [5:0] DIV_LAST_4 = 6'h03;
	localparam logic [5:0] DIV_LAST_8 = 6'h07;
	localparam logic [5:0] DIV_LAST_16 = 6'h0F;
	localparam logic [5:0] DIV_LAST_32 = 6'h1F;
	localparam logic [5:0] DIV_LAST_64 = 6'h3F;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_CONVERT = 2'b10,
		ST_GAP = 2'b11
	} acs_state_e;

	typedef struct packed {
		logic result_justify_select;
		logic reference_source_select;
		logic unused;
		logic [2:0] input_channel_select;
		logic go;
		logic converter_power_on;
	} acs_ctrl_a_s;

	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} acs_result_s;

endpackage : acs_pkg

// ===== src/acs_result_mem.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// result pair storage; no reset so contents survive device reset
module acs_result_mem
	import acs_pkg::*;
(
	input wire logic aclk,
	input wire logic we,
	input wire acs_result_s wr_pair,
	input wire logic rd_high,
	output logic [7:0] rd_data
);

	acs_result_s pair;

	// storage written only on a completed conversion
	always_ff @(posedge aclk) begin
		if (we) begin
			pair <= wr_pair;
		end
	end

	// registered read port
	always_ff @(posedge aclk) begin
		rd_data <= rd_high ? pair.high : pair.low;
	end

endmodule : acs_result_mem

`default_nettype wire

// ===== src/acs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

// Contract
// - two bit periods gap before next acquisition
// - sleep conversion only with RC clock
// - RC clock delays start one instruction cycle
// - completion clears go and loads result
// - sleep completion with enable wakes, maybe vectors
// - sleep completion without enable powers converter down
// - non-RC sleep aborts conversion, powers down
// - reset clears registers, aborts, keeps result; pin select resets to ones
// - result high holds upper bits per justification
// - completion sets flag; software clear aborts
// - conversion takes eleven bit periods
// - clock select codes dividers or RC
// - justify bit7, go bit1, power bit0
module acs_sequencer
	import acs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_active,
	input wire logic rc_tick,
	input wire logic comparator_high,
	output logic converter_enable,
	output logic sample_hold,
	output logic [RESULT_BITS-1:0] sar_trial,
	output logic [2:0] channel_select,
	output logic reference_select,
	output logic [7:0] analog_pins,
	output logic wake_pulse,
	output logic vector_request
);

	// ==========================================================
	// register state
	acs_ctrl_a_s ctrl_a;
	logic [2:0] clk_sel;
	logic [7:0] interrupt_control;
	logic [7:0] pie;
	logic done_flag;
	acs_state_e st;
	logic [3:0] seq_cnt;
	logic [5:0] div_cnt;
	logic [3:0] bit_pos;
	logic sleep_off;
	logic [7:0] rd_mem;

	// ==========================================================
	// write channel: address and data taken in either order
	logic aw_held, w_held;
	logic [7:0] aw_idx;
	logic [7:0] wbyte;
	logic wlane;
	logic wr_fire;

	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	// address capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_idx <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_idx <= s_axi_awaddr[9:2];
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	// data capture; only the low lane carries register bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			wbyte <= 8'h00;
			wlane <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			wbyte <= s_axi_wdata[7:0];
			wlane <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	logic mapped_w;
	always_comb begin
		case (aw_idx)
			IDX_INTERRUPT_CONTROL, IDX_PERIPHERAL_FLAGS, IDX_RESULT_HIGH,
			IDX_CONVERTER_CONTROL_A, IDX_PERIPHERAL_ENABLES, IDX_ANALOG_PIN_SELECT,
			IDX_RESULT_LOW, IDX_CONVERTER_CONTROL_B: mapped_w = 1'b1;
			default: mapped_w = 1'b0;
		endcase
	end

	// response; each ready held low while its channel holds a beat, and the next write waits for the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !wr_fire;
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !wr_fire;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped_w ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wr_en;
	assign wr_en = wr_fire && wlane;

	// ==========================================================
	// conversion clock: divided system clock or RC ticks
	logic rc_sel, tad_tick;
	logic [5:0] div_last;

	always_comb begin
		case (clk_sel)
			3'b000: div_last = DIV_LAST_2;
			3'b001: div_last = DIV_LAST_8;
			3'b010: div_last = DIV_LAST_32;
			3'b100: div_last = DIV_LAST_4;
			3'b101: div_last = DIV_LAST_16;
			3'b110: div_last = DIV_LAST_64;
			default: div_last = DIV_LAST_2;
		endcase
	end
	assign rc_sel = clk_sel[1:0] == CLK_SEL_RC_LOW[1:0];
	assign tad_tick = rc_sel ? rc_tick : (div_cnt == div_last);

	// divider free-runs outside RC mode, held at zero with RC; restarts when a period completes
	always_ff @(posedge aclk) begin
		if (!aresetn || rc_sel || div_cnt == div_last) begin
			div_cnt <= 6'h00;
		end else begin
			div_cnt <= div_cnt + 6'h01;
		end
	end

	// ==========================================================
	// sequence events
	logic ctrl_a_wr, busy, go_accept, sw_abort, sleep_abort, conv_done;
	acs_ctrl_a_s wr_a;

	assign wr_a = acs_ctrl_a_s'(wbyte);
	assign ctrl_a_wr = wr_en && aw_idx == IDX_CONVERTER_CONTROL_A;
	assign busy = st == ST_DELAY || st == ST_CONVERT;
	// go ignored while off, asleep-off or not idle
	assign go_accept = ctrl_a_wr && wr_a.go && ctrl_a.converter_power_on
		&& st == ST_IDLE && !sleep_off;
	assign sw_abort = ctrl_a_wr && busy && (!wr_a.go || !wr_a.converter_power_on);
	assign sleep_abort = sleep_active && !rc_sel && busy;
	assign conv_done = st == ST_CONVERT && tad_tick && seq_cnt == CONV_TADS - 4'h1
		&& !sw_abort && !sleep_abort;

	// ==========================================================
	// sequencer state; one counter serves delay, bit periods and gap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= ST_IDLE;
			seq_cnt <= 4'h0;
		end else begin
			case (st)
				ST_IDLE: begin
					seq_cnt <= 4'h0;
					if (go_accept) begin
						// RC clock waits an instruction cycle
						st <= rc_sel ? ST_DELAY : ST_CONVERT;
					end
				end
				ST_DELAY: begin
					if (sw_abort || sleep_abort) begin
						st <= ST_GAP;
						seq_cnt <= 4'h0;
					end else if (seq_cnt == START_DELAY_CLKS - 4'h1) begin
						st <= ST_CONVERT;
						seq_cnt <= 4'h0;
					end else begin
						seq_cnt <= seq_cnt + 4'h1;
					end
				end
				ST_CONVERT: begin
					if (sw_abort || sleep_abort || conv_done) begin
						st <= ST_GAP;
						seq_cnt <= 4'h0;
					end else if (tad_tick) begin
						seq_cnt <= seq_cnt + 4'h1;
					end
				end
				ST_GAP: begin
					// two bit periods before next acquisition
					if (tad_tick && seq_cnt == GAP_TADS - 4'h1) begin
						st <= ST_IDLE;
						seq_cnt <= 4'h0;
					end else if (tad_tick) begin
						seq_cnt <= seq_cnt + 4'h1;
					end
				end
				default: begin
					st <= ST_IDLE;
					seq_cnt <= 4'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// successive approximation: first period settles, then one bit per period
	logic [RESULT_BITS-1:0] next_sar;
	always_comb begin
		next_sar = sar_trial;
		if (seq_cnt != 4'h0) begin
			next_sar[bit_pos] = comparator_high;
			if (bit_pos != 4'h0) begin
				next_sar[bit_pos - 4'h1] = 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || st != ST_CONVERT) begin
			sar_trial <= {1'b1, {(RESULT_BITS-1){1'b0}}};
			bit_pos <= 4'(RESULT_BITS - 1);
		end else if (tad_tick) begin
			sar_trial <= next_sar;
			if (seq_cnt != 4'h0 && bit_pos != 4'h0) begin
				bit_pos <= bit_pos - 4'h1;
			end
		end
	end

	acs_result_s res_pair;
	always_comb begin
		if (ctrl_a.result_justify_select) begin
			res_pair.high = {6'h00, next_sar[9:8]};
			res_pair.low = next_sar[7:0];
		end else begin
			res_pair.high = next_sar[9:2];
			res_pair.low = {next_sar[1:0], 6'h00};
		end
	end

	// ==========================================================
	// control registers
	// pin select resets to ones, controls to zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_a <= acs_ctrl_a_s'(RST_CONVERTER_CONTROL);
			clk_sel <= 3'h0;
			interrupt_control <= RST_INTERRUPT_CONTROL;
			pie <= RST_PERIPHERAL_ENABLES;
			analog_pins <= RST_ANALOG_PIN_SELECT;
		end else begin
			if (ctrl_a_wr) begin
				ctrl_a.result_justify_select <= wr_a.result_justify_select;
				ctrl_a.reference_source_select <= wr_a.reference_source_select;
				ctrl_a.input_channel_select <= wr_a.input_channel_select;
				ctrl_a.converter_power_on <= wr_a.converter_power_on;
			end
			// go set by accepted start, cleared by end or abort
			if (go_accept) begin
				ctrl_a.go <= 1'b1;
			end else if (conv_done || sw_abort || sleep_abort) begin
				ctrl_a.go <= 1'b0;
			end
			if (wr_en && aw_idx == IDX_CONVERTER_CONTROL_B) begin
				clk_sel <= wbyte[6:4];
			end
			if (wr_en && aw_idx == IDX_INTERRUPT_CONTROL) begin
				interrupt_control <= wbyte;
			end
			if (wr_en && aw_idx == IDX_PERIPHERAL_ENABLES) begin
				pie <= wbyte;
			end
			if (wr_en && aw_idx == IDX_ANALOG_PIN_SELECT) begin
				analog_pins <= wbyte;
			end
		end
	end

	// done flag: hardware set wins over software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_flag <= RST_PERIPHERAL_FLAGS[BIT_CONVERSION_DONE_FLAG];
		end else if (conv_done) begin
			done_flag <= 1'b1;
		end else if (wr_en && aw_idx == IDX_PERIPHERAL_FLAGS) begin
			done_flag <= wbyte[BIT_CONVERSION_DONE_FLAG];
		end
	end

	// ==========================================================
	// sleep power-down, wake and converter pins
	logic irq_en;
	assign irq_en = pie[BIT_CONVERSION_IRQ_ENABLE];

	always_ff @(posedge aclk) begin
		if (!aresetn || !sleep_active) begin
			sleep_off <= 1'b0;
		// sleep abort or no interrupt: power down, power bit stays
		end else if (sleep_abort || (conv_done && !irq_en)) begin
			sleep_off <= 1'b1;
		end
	end

	// wake on completion in sleep with its enable, vector if global enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_pulse <= 1'b0;
			vector_request <= 1'b0;
			converter_enable <= 1'b0;
			sample_hold <= 1'b0;
			channel_select <= 3'h0;
			reference_select <= 1'b0;
		end else begin
			wake_pulse <= conv_done && sleep_active && irq_en;
			vector_request <= conv_done && sleep_active && irq_en
				&& interrupt_control[BIT_GLOBAL_IRQ_ENABLE];
			converter_enable <= ctrl_a.converter_power_on && !sleep_off;
			sample_hold <= ctrl_a.converter_power_on && !sleep_off && st != ST_CONVERT;
			channel_select <= ctrl_a.input_channel_select;
			reference_select <= ctrl_a.reference_source_select;
		end
	end

	// result storage, loaded only by a completed conversion
	acs_result_mem u_result (
		.aclk(aclk),
		.we(conv_done),
		.wr_pair(res_pair),
		.rd_high(s_axi_araddr[9:2] == IDX_RESULT_HIGH),
		.rd_data(rd_mem)
	);

	// ==========================================================
	// read channel: one pending cycle for the result memory
	logic rd_pend;
	logic [7:0] rd_idx;
	logic [7:0] rd_byte;
	logic rd_ok;

	always_comb begin
		rd_ok = 1'b1;
		case (rd_idx)
			IDX_INTERRUPT_CONTROL: rd_byte = interrupt_control;
			IDX_PERIPHERAL_FLAGS: rd_byte = 8'(done_flag) << BIT_CONVERSION_DONE_FLAG;
			IDX_RESULT_HIGH, IDX_RESULT_LOW: rd_byte = rd_mem;
			IDX_CONVERTER_CONTROL_A: rd_byte = ctrl_a & 8'hDF;
			IDX_PERIPHERAL_ENABLES: rd_byte = pie;
			IDX_ANALOG_PIN_SELECT: rd_byte = analog_pins;
			IDX_CONVERTER_CONTROL_B: rd_byte = {1'b0, clk_sel, 4'h0};
			default: begin
				rd_byte = 8'h00;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
			rd_pend <= 1'b0;
			rd_idx <= 8'h00;
		end else begin
			rd_pend <= s_axi_arvalid && s_axi_arready;
			s_axi_arready <= !s_axi_rvalid && !rd_pend && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				rd_idx <= s_axi_araddr[9:2];
			end
			if (rd_pend) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_byte};
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// checks
	logic [3:0] tad_seen;
	always_ff @(posedge aclk) begin
		if (!aresetn || st != ST_CONVERT) begin
			tad_seen <= 4'h0;
		end else if (tad_tick) begin
			tad_seen <= tad_seen + 4'h1;
		end
	end

	sequence s_rc_wait;
		(st == ST_DELAY) [*4];
	endsequence
	sequence s_power_down;
		##1 sleep_off ##1 !converter_enable;
	endsequence

	property p_go_needs_power;
		@(posedge aclk) disable iff (!aresetn)
		(st == ST_IDLE && st != $past(st) && 1'b0) or (st == ST_IDLE ##1 st != ST_IDLE
			&& st != ST_GAP) |-> $past(ctrl_a.converter_power_on);
	endproperty
	a_go_needs_power: assert property (p_go_needs_power) else $error("start while off");
	property p_done_effects;
		@(posedge aclk) disable iff (!aresetn)
		conv_done |=> done_flag && !ctrl_a.go && st == ST_GAP;
	endproperty
	a_done_effects: assert property (p_done_effects) else $error("done effects missing");
	property p_conv_len;
		@(posedge aclk) disable iff (!aresetn)
		conv_done |-> tad_seen == CONV_TADS - 4'h1;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
	property p_gap_blocks;
		@(posedge aclk) disable iff (!aresetn)
		st == ST_GAP && ctrl_a_wr && wr_a.go |=> !ctrl_a.go && st != ST_DELAY && st != ST_CONVERT;
	endproperty
	a_gap_blocks: assert property (p_gap_blocks) else $error("start during gap");
	property p_rc_delay;
		@(posedge aclk) disable iff (!aresetn)
		go_accept && rc_sel |=> s_rc_wait ##1 (st == ST_CONVERT || st == ST_GAP);
	endproperty
	a_rc_delay: assert property (p_rc_delay) else $error("rc start delay wrong");
	property p_sleep_abort;
		@(posedge aclk) disable iff (!aresetn)
		sleep_abort && sleep_active [*1] ##0 $stable(sleep_active) |-> s_power_down;
	endproperty
	a_sleep_abort: assert property (p_sleep_abort) else $error("sleep abort lost");
	property p_abort_keeps;
		@(posedge aclk) disable iff (!aresetn)
		sw_abort |=> !conv_done [*2];
	endproperty
	a_abort_keeps: assert property (p_abort_keeps) else $error("aborted result stored");
	property p_wake;
		@(posedge aclk) disable iff (!aresetn)
		conv_done && sleep_active && irq_en |=> wake_pulse
			&& vector_request == $past(interrupt_control[BIT_GLOBAL_IRQ_ENABLE]);
	endproperty
	a_wake: assert property (p_wake) else $error("wake missing");
	property p_justify;
		@(posedge aclk) disable iff (!aresetn)
		conv_done && ctrl_a.result_justify_select |-> res_pair.high[7:2] == 6'h00;
	endproperty
	a_justify: assert property (p_justify) else $error("padding not zero");
	property p_reset;
		@(posedge aclk) !aresetn |=> st == ST_IDLE && !ctrl_a.converter_power_on
			&& analog_pins == RST_ANALOG_PIN_SELECT;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule : acs_sequencer

`default_nettype wire
